// *** include/adc_ctrl_consts.vh ***
// Purpose: register offsets, field positions and codes of the converter control block
// Assumes: APB, one aligned 32-bit word per register, 8-bit data in the low bits
// Notes:   definitions only
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

`define OFS_RESULT_LOW      12'h000
`define OFS_RESULT_HIGH     12'h004
`define OFS_CONV_CTRL       12'h008
`define OFS_SRC_CLK_CTRL    12'h00c
`define OFS_REF_AMP_CTRL    12'h010
`define OFS_BANDGAP_CTRL    12'h014
`define ADDR_MSB            11
`define ADDR_LSB            2

`define CC_START            7
`define CC_BUSY             6
`define CC_ENABLE           5
`define CC_FORMAT           4
`define CC_CHAN_MSB         3
`define CC_CHAN_LSB         0
`define SC_SRC_MSB          7
`define SC_SRC_LSB          4
`define SC_CLK_MSB          2
`define SC_CLK_LSB          0

`define CONV_CTRL_WMASK     8'hbf
`define SRC_CLK_WMASK       8'hf7
`define REF_AMP_WMASK       8'h9f
`define BANDGAP_WMASK       8'h01
`define REG_RESET           8'h00

`define LAST_CHANNEL        4'hb
`define NUM_CHANNELS        12
`define SRC_EXT0            4'h0
`define SRC_AVDD            4'h1
`define SRC_AVDD_HALF       4'h2
`define SRC_AVDD_QTR        4'h3
`define SRC_EXT1            4'h4
`define SRC_VR              4'h5
`define SRC_VR_HALF         4'h6
`define SRC_VR_QTR          4'h7
`define SRC_GROUND_HI2      2'b10

`define ROUTE_NONE          3'h0
`define ROUTE_EXT           3'h1
`define ROUTE_AVDD          3'h2
`define ROUTE_VR            3'h3
`define ROUTE_GROUND        3'h4

`define CONV_CYCLES         5'd16
`endif

// *** logic/adc_control_sequencer.v ***
// Purpose: control and result logic for a 12-bit successive-approximation converter
// Assumes: APB slave on the system clock; analog core answers with a 12-bit sample
// Notes:   zero wait states; unmapped addresses read zero and set pslverr
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

// Overview of operation
// - each conversion yields 12-bit unsigned result
// - internal source disconnects the external channel
// - format 0: high=D11..4, low upper=D3..0
// - format 1: high lower=D11..8, low=D7..0
// - unused result bits read as zero
// - disabled converter leaves results untouched
// - start bit high then low starts conversion
// - busy set after start, cleared when done
// - clear enable powers the converter down
// - channel codes 0..11 pick inputs, rest float
// - source 0000,0100,11xx route external channel
// - source 0001..0011 route supply, half, quarter
// - source 0101..0111 route amp output, fractions
// - source 10xx grounds converter input
// - clock select divides system clock by 2^code
// - analog pin drops digital use and pull-high
module adc_control_sequencer #(
  parameter DATA_W = 12,
  parameter CH_N   = `NUM_CHANNELS
) (
  input  wire              clock,
  input  wire              nrst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [DATA_W-1:0] sample_data,
  output reg               converter_power_on,
  output reg               sample_strobe,
  output reg               conversion_clock_en,
  output reg  [CH_N-1:0]   analog_input_n,
  output reg  [2:0]        source_route,
  output reg  [1:0]        source_divide,
  input  wire [CH_N-1:0]   pin_analog_select,
  output reg  [CH_N-1:0]   pin_digital_en,
  output reg  [CH_N-1:0]   pin_pullup_en,
  input  wire [CH_N-1:0]   pin_pullup_req,
  output reg  [7:0]        reference_amp_control,
  output reg               bandgap_enable
);

  localparam ST_IDLE = 2'b00;
  localparam ST_ARMED = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [7:0]        conv_ctrl_q;
  reg [7:0]        src_clk_ctrl_q;
  reg [7:0]        bandgap_ctrl_q;
  reg [DATA_W-1:0] result_q;
  reg [1:0]        state_q;
  reg [4:0]        tick_cnt_q;
  reg [6:0]        div_cnt_q;
  reg [DATA_W-1:0] sample_s1_q;
  reg [DATA_W-1:0] sample_s2_q;
  reg [7:0]        rd_byte;
  reg              addr_ok;
  reg [2:0]        route_d;
  reg [1:0]        divide_d;
  reg [CH_N-1:0]   chan_d;
  reg              div_tick;
  reg [6:0]        div_limit;

  wire       wr_access = psel & penable & pwrite;
  wire       start_bit = conv_ctrl_q[`CC_START];
  wire       enabled   = conv_ctrl_q[`CC_ENABLE];
  wire [3:0] src_sel   = src_clk_ctrl_q[`SC_SRC_MSB:`SC_SRC_LSB];
  wire [3:0] chan_sel  = conv_ctrl_q[`CC_CHAN_MSB:`CC_CHAN_LSB];
  wire [2:0] clk_sel   = src_clk_ctrl_q[`SC_CLK_MSB:`SC_CLK_LSB];

  // aligned high byte of the result
  function [7:0] high_byte;
    input             fmt;
    input [DATA_W-1:0] d;
    begin
      if (fmt)
        high_byte = {4'h0, d[11:8]};
      else
        high_byte = d[11:4];
    end
  endfunction

  // aligned low byte of the result
  function [7:0] low_byte;
    input             fmt;
    input [DATA_W-1:0] d;
    begin
      if (fmt)
        low_byte = d[7:0];
      else
        low_byte = {d[3:0], 4'h0};
    end
  endfunction

  // read mux and address decode
  always @* begin
    rd_byte = 8'h00;
    addr_ok = 1'b1;
    case (paddr)
      `OFS_RESULT_LOW:   rd_byte = low_byte(conv_ctrl_q[`CC_FORMAT], result_q);
      `OFS_RESULT_HIGH:  rd_byte = high_byte(conv_ctrl_q[`CC_FORMAT], result_q);
      `OFS_CONV_CTRL:    rd_byte = conv_ctrl_q;
      `OFS_SRC_CLK_CTRL: rd_byte = src_clk_ctrl_q;
      `OFS_REF_AMP_CTRL: rd_byte = reference_amp_control;
      `OFS_BANDGAP_CTRL: rd_byte = bandgap_ctrl_q;
      default:           addr_ok = 1'b0;
    endcase
  end

  // input routing decode
  always @* begin
    route_d  = `ROUTE_EXT;
    divide_d = 2'd0;
    case (src_sel)
      `SRC_EXT0, `SRC_EXT1: route_d = `ROUTE_EXT;
      `SRC_AVDD:            route_d = `ROUTE_AVDD;
      `SRC_AVDD_HALF: begin
        route_d  = `ROUTE_AVDD;
        divide_d = 2'd1;
      end
      `SRC_AVDD_QTR: begin
        route_d  = `ROUTE_AVDD;
        divide_d = 2'd2;
      end
      `SRC_VR:              route_d = `ROUTE_VR;
      `SRC_VR_HALF: begin
        route_d  = `ROUTE_VR;
        divide_d = 2'd1;
      end
      `SRC_VR_QTR: begin
        route_d  = `ROUTE_VR;
        divide_d = 2'd2;
      end
      default: begin
        if (src_sel[3:2] == `SRC_GROUND_HI2)
          route_d = `ROUTE_GROUND;
        else
          route_d = `ROUTE_EXT;
      end
    endcase
    chan_d = {CH_N{1'b0}};
    if (route_d == `ROUTE_EXT && chan_sel <= `LAST_CHANNEL)
      chan_d[chan_sel] = 1'b1;
    if (route_d == `ROUTE_EXT && chan_sel > `LAST_CHANNEL)
      route_d = `ROUTE_NONE;
  end

  // conversion clock divider
  always @* begin
    div_limit = (7'h01 << clk_sel) - 7'h01;
    div_tick  = (div_cnt_q == div_limit);
  end

  // register writes
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      conv_ctrl_q           <= `REG_RESET;
      src_clk_ctrl_q        <= `REG_RESET;
      reference_amp_control <= `REG_RESET;
      bandgap_ctrl_q        <= `REG_RESET;
    end else begin
      if (wr_access && paddr == `OFS_CONV_CTRL)
        conv_ctrl_q <= (pwdata[7:0] & `CONV_CTRL_WMASK) | (conv_ctrl_q & ~`CONV_CTRL_WMASK);
      else
        conv_ctrl_q[`CC_BUSY] <= (state_q == ST_CONV);
      if (wr_access && paddr == `OFS_CONV_CTRL)
        conv_ctrl_q[`CC_BUSY] <= (state_q == ST_CONV);
      if (wr_access && paddr == `OFS_SRC_CLK_CTRL)
        src_clk_ctrl_q <= pwdata[7:0] & `SRC_CLK_WMASK;
      if (wr_access && paddr == `OFS_REF_AMP_CTRL)
        reference_amp_control <= pwdata[7:0] & `REF_AMP_WMASK;
      if (wr_access && paddr == `OFS_BANDGAP_CTRL)
        bandgap_ctrl_q <= pwdata[7:0] & `BANDGAP_WMASK;
    end
  end

  // start sequencer, busy and result capture
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      tick_cnt_q  <= 5'd0;
      div_cnt_q   <= 7'd0;
      result_q    <= {DATA_W{1'b0}};
      sample_s1_q <= {DATA_W{1'b0}};
      sample_s2_q <= {DATA_W{1'b0}};
    end else begin
      sample_s1_q <= sample_data;
      sample_s2_q <= sample_s1_q;
      div_cnt_q   <= div_tick ? 7'd0 : div_cnt_q + 7'd1;
      case (state_q)
        ST_IDLE: begin
          if (start_bit && enabled)
            state_q <= ST_ARMED;
        end
        ST_ARMED: begin
          if (!enabled)
            state_q <= ST_IDLE;
          else if (!start_bit) begin
            state_q    <= ST_CONV;
            tick_cnt_q <= 5'd0;
          end
        end
        ST_CONV: begin
          if (!enabled)
            state_q <= ST_IDLE;
          else if (div_tick) begin
            if (tick_cnt_q == `CONV_CYCLES - 5'd1) begin
              result_q <= sample_s2_q;
              state_q  <= ST_IDLE;
            end else
              tick_cnt_q <= tick_cnt_q + 5'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // registered outputs
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      converter_power_on  <= 1'b0;
      sample_strobe       <= 1'b0;
      conversion_clock_en <= 1'b0;
      analog_input_n      <= {CH_N{1'b0}};
      source_route        <= `ROUTE_NONE;
      source_divide       <= 2'd0;
      pin_digital_en      <= {CH_N{1'b1}};
      pin_pullup_en       <= {CH_N{1'b0}};
      bandgap_enable      <= 1'b0;
    end else begin
      pready              <= psel & ~penable;
      pslverr             <= psel & ~penable & ~addr_ok;
      prdata              <= {24'h000000, rd_byte};
      converter_power_on  <= enabled;
      sample_strobe       <= (state_q == ST_CONV) && enabled && div_tick &&
                             (tick_cnt_q == `CONV_CYCLES - 5'd1);
      conversion_clock_en <= (state_q == ST_CONV) && div_tick;
      analog_input_n      <= chan_d;
      source_route        <= route_d;
      source_divide       <= divide_d;
      pin_digital_en      <= ~pin_analog_select;
      pin_pullup_en       <= pin_pullup_req & ~pin_analog_select;
      bandgap_enable      <= bandgap_ctrl_q[0];
    end
  end

endmodule // adc_control_sequencer

// *** bench/adc_seq_assertions.sv ***
// Purpose: port checks for the converter control block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module adc_seq_checker #(parameter CH_N = 12) (
  input logic            clock,
  input logic            nrst,
  input logic            psel,
  input logic            penable,
  input logic            pready,
  input logic            pslverr,
  input logic [31:0]     prdata,
  input logic [CH_N-1:0] analog_input_n,
  input logic [2:0]      source_route,
  input logic [CH_N-1:0] pin_analog_select,
  input logic [CH_N-1:0] pin_digital_en,
  input logic [CH_N-1:0] pin_pullup_req,
  input logic [CH_N-1:0] pin_pullup_en,
  input logic            sample_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  AST_READY_PULSE: assert property (s_setup |=> s_answer)
    else $error("pready is not a one-cycle answer");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_READ_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_CHAN_ONEHOT: assert property ($onehot0(analog_input_n))
    else $error("more than one channel switch closed");
  AST_EXT_OFF: assert property (source_route != `ROUTE_EXT |-> analog_input_n == '0)
    else $error("channel switch closed while not external");
  AST_DIGITAL_OFF: assert property (1 |=> pin_digital_en == ~$past(pin_analog_select))
    else $error("digital function kept on analog pin");
  AST_PULLUP_OFF: assert property (1 |=> pin_pullup_en == ($past(pin_pullup_req) & ~$past(pin_analog_select)))
    else $error("pull-high kept on analog pin");
  AST_STROBE_PULSE: assert property (sample_strobe |=> !sample_strobe)
    else $error("store strobe longer than one cycle");
endmodule // adc_seq_checker

bind adc_control_sequencer adc_seq_checker #(.CH_N(CH_N)) u_chk (.clock, .nrst, .psel, .penable, .pready,
  .pslverr, .prdata, .analog_input_n, .source_route, .pin_analog_select, .pin_digital_en, .pin_pullup_req,
  .pin_pullup_en, .sample_strobe);

// *** bench/adc_control_sequencer_tb.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait APB slave, 250 MHz clock
// Notes:   fixed seed, corner cases among random values
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module adc_control_sequencer_tb;
  logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0, sample_data = 0, pin_analog_select = 0, pin_pullup_req = 0;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] ex;
  logic [3:0]  src, ch;
  logic [7:0]  d;
  wire  [31:0] prdata;
  wire         pready, pslverr, converter_power_on, sample_strobe, conversion_clock_en, bandgap_enable;
  wire  [11:0] analog_input_n, pin_digital_en, pin_pullup_en;
  wire  [2:0]  source_route;
  wire  [1:0]  source_divide;
  wire  [7:0]  reference_amp_control;
  int          fails = 0, n_checks = 0, k, k2;
  logic [11:0] ofs [3] = '{12'h00c, 12'h010, 12'h014};
  logic [7:0]  msk [3] = '{`SRC_CLK_WMASK, `REF_AMP_WMASK, `BANDGAP_WMASK};
  always #2 clock = ~clock;
  always @(posedge clock) begin
    pin_analog_select <= $urandom;
    pin_pullup_req <= $urandom;
  end
  adc_control_sequencer DUT (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sample_data, .converter_power_on, .sample_strobe, .conversion_clock_en, .analog_input_n,
    .source_route, .source_divide, .pin_analog_select, .pin_digital_en, .pin_pullup_en, .pin_pullup_req,
    .reference_amp_control, .bandgap_enable);
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    if (pready !== 1'b1) begin fails++; final_report; end
    @(posedge clock);
  endtask
  function automatic logic [2:0] route(input logic [3:0] s, input logic [3:0] c);
    if (s >= 1 && s <= 3) return `ROUTE_AVDD;
    if (s >= 5 && s <= 7) return `ROUTE_VR;
    if (s[3:2] == `SRC_GROUND_HI2) return `ROUTE_GROUND;
    return (c > `LAST_CHANNEL) ? `ROUTE_NONE : `ROUTE_EXT;
  endfunction
  initial begin
    void'($urandom(32'hed78));
    repeat (10) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    for (int a = 0; a < 7; a++) begin
      apb(0, 12'(a * 4), 0); chk("reset value", 0, rd);
      chk("slave error", a == 6, err);
    end
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      apb(1, ofs[i % 3], d);
      apb(0, ofs[i % 3], 0); chk("register", d & msk[i % 3], rd);
      if (i % 3 == 1) chk("amp port", d & msk[1], reference_amp_control);
      if (i % 3 == 2) chk("bandgap port", d[0], bandgap_enable);
    end
    for (int i = 0; i < 32; i++) begin
      src = (i < 16) ? 4'h0 : 4'(i);
      ch = (i < 16) ? 4'(i) : 4'($urandom);
      apb(1, 12'h00c, {src, 4'h0});
      apb(1, 12'h008, {4'h2, ch});
      @(posedge clock);
      chk("route", route(src, ch), source_route);
      chk("divide", (route(src, ch) inside {`ROUTE_AVDD, `ROUTE_VR}) ? src[1:0] - 2'h1 : 2'h0, source_divide);
      chk("channel", (route(src, ch) == `ROUTE_EXT) ? 12'h1 << ch : 12'h0, analog_input_n);
      chk("power", 1, converter_power_on);
    end
    for (int i = 0; i < 8; i++) begin
      sample_data <= $urandom;
      apb(1, 12'h00c, {5'h0, 3'(i)});
      apb(1, 12'h008, {3'b101, i[0], 4'h0});
      apb(1, 12'h008, {3'b001, i[0], 4'h0});
      @(posedge clock);
      apb(0, 12'h008, 0); chk("busy set", 1, rd[6]);
      k2 = 0;
      do apb(0, 12'h008, 0); while (rd[6] === 1'b1 && k2++ < 1000);
      if (rd[6] !== 1'b0) begin fails++; final_report; end
      ex = i[0] ? {4'h0, sample_data} : {sample_data, 4'h0};
      apb(0, 12'h004, 0); chk("result high", ex[15:8], rd);
      apb(0, 12'h000, 0); chk("result low", ex[7:0], rd);
    end
    sample_data <= ~sample_data;
    apb(1, 12'h008, 8'hb0);
    apb(1, 12'h008, 8'h30);
    apb(1, 12'h008, 8'h10);
    repeat (40) @(posedge clock);
    chk("power off", 0, converter_power_on);
    apb(0, 12'h004, 0); chk("kept high", ex[15:8], rd);
    apb(0, 12'h000, 0); chk("kept low", ex[7:0], rd);
    final_report;
  end
endmodule // adc_control_sequencer_tb
